// ---- rpg_gate.sv ----
// Read-protection gate for outside access to on-chip flash.
// Assumes the flash word is presented after reset with a valid strobe and
// that boot-programming commands arrive already classified.
`timescale 1ns/100ps
module rpg_gate
  import rpg_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                nrst,
  // Dedicated flash word
  input  wire logic [31:0]         prot_word,
  input  wire logic                prot_word_valid,
  // Boot-programming entry requests (pin at load, software request while running)
  input  wire logic                boot_override_pin,
  input  wire logic                sw_reinvoke_req,
  // JTAG access request
  input  wire logic                jtag_req,
  // Boot-programming command
  input  wire logic                bsp_cmd_valid,
  input  wire rpg_pkg::rpg_cmd_t   bsp_cmd,
  input  wire logic [7:0]          bsp_sector,
  // In-application programming command
  input  wire logic                iap_cmd_valid,
  // Results
  output logic                     level_ready,
  output rpg_pkg::rpg_level_t      level_out,
  output logic                     jtag_enable,
  output logic                     bsp_enter,
  output logic                     bsp_active,
  output logic                     bsp_cmd_accept,
  output logic                     bsp_cmd_reject,
  output logic                     iap_cmd_accept,
  output logic                     uart_route
);

  typedef struct packed {
    rpg_state_t st;
    rpg_level_t level;
    logic       jtag_en;
    logic       bsp_on;
    logic       erased;
    logic       acc;
    logic       rej;
    logic       iap_acc;
    logic       enter;
  } rpg_state_s_t;

  rpg_state_s_t s_reg;
  rpg_state_s_t s_next;
  rpg_level_t   dec_level;
  logic         cmd_ok;

  rpg_level_decode u_dec (
    .prot_word (prot_word),
    .level     (dec_level)
  );

  // Per-level filter of boot-programming commands.
  // The filter looks only at the stored level, never at the live flash
  // word, so a word that changes after load cannot widen access.
  // Open: every class passes.
  // Partial: info and go pass; write and sector erase pass away from
  // sector 0, so the boot vector area can never be replaced.
  // Erase-only: no partial update; a write is taken only once a
  // whole-device erase has been accepted in this session.
  // Full: the boot path exists only after software re-entry.
  always_comb
  begin
    cmd_ok = 1'b0;
    case (s_reg.level)
      RPG_LVL_OPEN:
      begin
        cmd_ok = 1'b1;
      end
      RPG_LVL_PARTIAL:
      begin
        case (bsp_cmd)
          RPG_CMD_INFO, RPG_CMD_GO:
            cmd_ok = 1'b1;
          RPG_CMD_WRITE, RPG_CMD_ERASE:
            cmd_ok = (bsp_sector != RPG_SECTOR0);
          default:
            cmd_ok = 1'b0;
        endcase
      end
      RPG_LVL_ERASE:
      begin
        case (bsp_cmd)
          RPG_CMD_INFO, RPG_CMD_ERASEALL:
            cmd_ok = 1'b1;
          // Programming only after a whole-device erase
          RPG_CMD_WRITE:
            cmd_ok = s_reg.erased;
          default:
            cmd_ok = 1'b0;
        endcase
      end
      // Full lock reaches here only after software re-entry
      RPG_LVL_FULL:
      begin
        cmd_ok = 1'b1;
      end
      default:
      begin
        cmd_ok = 1'b0;
      end
    endcase
  end

  // Sequencing: one idle cycle after reset, then the flash word is
  // awaited; the level is frozen on the first valid cycle and kept until
  // the next reset. Entry into boot programming is sticky for the same
  // reason: the loader owns the serial port until the part restarts.
  // Answers to commands and to application calls are one-cycle pulses.

  always_comb
  begin
    s_next         = s_reg;
    s_next.acc     = 1'b0;
    s_next.rej     = 1'b0;
    s_next.enter   = 1'b0;
    s_next.iap_acc = iap_cmd_valid;
    case (s_reg.st)
      RPG_ST_RESET:
      begin
        s_next.st = RPG_ST_LOAD;
      end
      RPG_ST_LOAD:
      begin
        if (prot_word_valid)
        begin
          s_next.st      = RPG_ST_RUN;
          s_next.level   = dec_level;
          s_next.jtag_en = (dec_level == RPG_LVL_OPEN);
          // Override pin counts only below full lock
          if (boot_override_pin && dec_level != RPG_LVL_FULL)
          begin
            s_next.bsp_on = 1'b1;
            s_next.enter  = 1'b1;
          end
        end
      end
      RPG_ST_RUN:
      begin
        if (sw_reinvoke_req && !s_reg.bsp_on)
        begin
          s_next.bsp_on = 1'b1;
          s_next.enter  = 1'b1;
        end
        if (bsp_cmd_valid)
        begin
          // No boot path without entry: full lock stays shut
          if (s_reg.bsp_on && cmd_ok)
          begin
            s_next.acc = 1'b1;
            if (bsp_cmd == RPG_CMD_ERASEALL)
              s_next.erased = 1'b1;
          end
          else
            s_next.rej = 1'b1;
        end
      end
      default:
      begin
        s_next.st = RPG_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg         <= '0;
      s_reg.st      <= RPG_ST_RESET;
      s_reg.level   <= RPG_LEVEL_RST;
    end
    else
      s_reg <= s_next;
  end

  assign level_ready    = (s_reg.st == RPG_ST_RUN);
  assign level_out      = s_reg.level;
  // Debug is held off until the level is known
  assign jtag_enable    = s_reg.jtag_en && jtag_req;
  assign bsp_enter      = s_reg.enter;
  assign bsp_active     = s_reg.bsp_on;
  assign bsp_cmd_accept = s_reg.acc;
  assign bsp_cmd_reject = s_reg.rej;
  assign iap_cmd_accept = s_reg.iap_acc;
  assign uart_route     = s_reg.bsp_on;

endmodule

// ---- rpg_pkg.sv ----
// Package for the read-protection gate: level patterns, level codes,
// command classes and reset values.
// Assumes a single core clock domain and no software-visible registers.
package rpg_pkg;

  // Protection patterns held in the dedicated flash word (plain defaults)
  localparam logic [31:0] RPG_PAT_PARTIAL = 32'h12345678;
  localparam logic [31:0] RPG_PAT_ERASE   = 32'h87654321;
  localparam logic [31:0] RPG_PAT_FULL    = 32'h43218765;

  typedef enum logic [1:0] {
    RPG_LVL_OPEN    = 2'h0,
    RPG_LVL_PARTIAL = 2'h1,
    RPG_LVL_ERASE   = 2'h2,
    RPG_LVL_FULL    = 2'h3
  } rpg_level_t;

  // Boot-programming command classes, as decoded upstream
  typedef enum logic [2:0] {
    RPG_CMD_INFO    = 3'h0,
    RPG_CMD_READ    = 3'h1,
    RPG_CMD_WRITE   = 3'h2,
    RPG_CMD_ERASE   = 3'h3,
    RPG_CMD_ERASEALL= 3'h4,
    RPG_CMD_GO      = 3'h5
  } rpg_cmd_t;

  // Gate states, Gray coded along reset -> load -> run
  typedef enum logic [1:0] {
    RPG_ST_RESET = 2'h0,
    RPG_ST_LOAD  = 2'h1,
    RPG_ST_RUN   = 2'h3
  } rpg_state_t;

  localparam rpg_level_t RPG_LEVEL_RST = RPG_LVL_FULL;
  localparam logic [7:0] RPG_SECTOR0   = 8'h00;

endpackage

// ---- rpg_level_decode.sv ----
// Level decoder: maps the dedicated flash word onto a protection level.
// Assumes the word is stable while its valid strobe is high.
`timescale 1ns/100ps
module rpg_level_decode
  import rpg_pkg::*;
(
  // Flash word
  input  wire logic [31:0]         prot_word,
  // Decoded level
  output rpg_pkg::rpg_level_t      level
);

  always_comb
  begin
    case (prot_word)
      RPG_PAT_PARTIAL: level = RPG_LVL_PARTIAL;
      RPG_PAT_ERASE:   level = RPG_LVL_ERASE;
      RPG_PAT_FULL:    level = RPG_LVL_FULL;
      default:         level = RPG_LVL_OPEN;
    endcase
  end

endmodule

// ---- rpg_gate_chk.sv ----
// Port-level checks of the read-protection gate.
// Bound to every rpg_gate instance; sees only its ports.
`timescale 1ns/100ps
module rpg_gate_chk
  import rpg_pkg::*;
(
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                nrst,
  // Requests
  input wire logic                jtag_req,
  input wire logic                bsp_cmd_valid,
  input wire rpg_pkg::rpg_cmd_t   bsp_cmd,
  input wire logic [7:0]          bsp_sector,
  input wire logic                iap_cmd_valid,
  // Results
  input wire logic                level_ready,
  input wire rpg_pkg::rpg_level_t level_out,
  input wire logic                jtag_enable,
  input wire logic                bsp_active,
  input wire logic                bsp_cmd_accept,
  input wire logic                bsp_cmd_reject,
  input wire logic                iap_cmd_accept
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  wire tk = bsp_cmd_valid && level_ready;
  wire s0 = bsp_sector == RPG_SECTOR0;
  a_iap_pass: assert property (
    iap_cmd_valid && level_ready |=> iap_cmd_accept) else $error("iap lost");
  a_jtag_gate: assert property (
    jtag_enable == (jtag_req && level_ready && level_out == RPG_LVL_OPEN))
    else $error("jtag gate wrong");
  a_one_answer: assert property (
    tk |=> bsp_cmd_accept ^ bsp_cmd_reject) else $error("no single answer");
  a_no_answer: assert property (
    !tk |=> !bsp_cmd_accept && !bsp_cmd_reject) else $error("stray answer");
  a_idle_reject: assert property (
    tk && !bsp_active |=> bsp_cmd_reject) else $error("idle cmd passed");
  a_sector_zero: assert property (tk && level_out == RPG_LVL_PARTIAL &&
    (bsp_cmd == RPG_CMD_READ || (bsp_cmd inside {RPG_CMD_WRITE, RPG_CMD_ERASE}
    && s0)) |=> bsp_cmd_reject) else $error("partial filter open");
  a_erase_only: assert property (tk && level_out == RPG_LVL_ERASE &&
    bsp_cmd inside {RPG_CMD_READ, RPG_CMD_ERASE} |=> bsp_cmd_reject)
    else $error("erase-only filter open");
  a_open_all: assert property (
    tk && bsp_active && level_out == RPG_LVL_OPEN |=> bsp_cmd_accept)
    else $error("open level refused");
endmodule

bind rpg_gate rpg_gate_chk u_chk (.core_clk, .nrst, .jtag_req,
  .bsp_cmd_valid, .bsp_cmd, .bsp_sector, .iap_cmd_valid, .level_ready,
  .level_out, .jtag_enable, .bsp_active, .bsp_cmd_accept, .bsp_cmd_reject,
  .iap_cmd_accept);

// ---- rpg_dbg_model.sv ----
// Debugger model: asks for JTAG access on alternate cycles.
// Assumes it shares the gate's core clock.
`timescale 1ns/100ps
module rpg_dbg_model
(
  input  wire logic core_clk,
  output logic      jtag_req
);
  initial jtag_req = 1'b0;
  // Toggling shows that the enable follows the request, not a constant
  always @(posedge core_clk) jtag_req <= ~jtag_req;
endmodule

// ---- rpg_gate_tb.sv ----
// Testbench for rpg_gate: one test section per protection level, run in sequence.
// Assumes the debugger model drives jtag_req.
`timescale 1ns/100ps
module rpg_gate_tb;
  import rpg_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, prot_word_valid = 1'b1;
  logic boot_override_pin = 1'b1, sw_reinvoke_req = 1'b0, jtag_req;
  logic bsp_cmd_valid = 1'b0, iap_cmd_valid = 1'b0;
  logic [31:0] prot_word = 32'h0;
  logic [7:0] bsp_sector = 8'h0;
  rpg_cmd_t bsp_cmd = RPG_CMD_INFO;
  rpg_level_t level_out;
  logic level_ready, jtag_enable, bsp_enter, bsp_active, bsp_cmd_accept;
  logic bsp_cmd_reject, iap_cmd_accept, uart_route;
  int fail_count = 0;
  int compares = 0;
  rpg_dbg_model PM (.core_clk, .jtag_req);
  rpg_gate DUT (.core_clk, .nrst, .prot_word, .prot_word_valid,
    .boot_override_pin, .sw_reinvoke_req, .jtag_req, .bsp_cmd_valid,
    .bsp_cmd, .bsp_sector, .iap_cmd_valid, .level_ready, .level_out,
    .jtag_enable, .bsp_enter, .bsp_active, .bsp_cmd_accept,
    .bsp_cmd_reject, .iap_cmd_accept, .uart_route);
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rst(logic [31:0] w, rpg_level_t l);
    @(posedge core_clk);
    nrst <= 1'b0;
    prot_word <= w;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9 && level_ready !== 1'b1; i++)
      @(posedge core_clk) #1;
    if (level_ready !== 1'b1)
    begin
      fail_count++;
      summarize();
    end
    chk("level", level_out, l);
    chk("enter", bsp_enter, l != RPG_LVL_FULL);
    @(posedge core_clk);
    iap_cmd_valid <= 1'b1;
    @(posedge core_clk);
    iap_cmd_valid <= 1'b0;
    #1 chk("iap", iap_cmd_accept, 1);
  endtask
  task automatic cm(rpg_cmd_t k, logic [7:0] t, logic a);
    @(posedge core_clk);
    bsp_cmd_valid <= 1'b1;
    bsp_cmd <= k;
    bsp_sector <= t;
    @(posedge core_clk);
    bsp_cmd_valid <= 1'b0;
    #1 chk("accept", bsp_cmd_accept, a);
    chk("reject", bsp_cmd_reject, !a);
  endtask
  // Waits for a cycle in which the debugger is asking
  task automatic jt(logic e);
    @(posedge core_clk iff jtag_req === 1'b0) #1 chk("jtag", jtag_enable, e);
  endtask
  initial
  begin
    rst(32'h0, RPG_LVL_OPEN);
    jt(1);
    cm(RPG_CMD_WRITE, 8'h00, 1);
    cm(RPG_CMD_READ, 8'h00, 1);
    $display("test open done");
    rst(RPG_PAT_PARTIAL, RPG_LVL_PARTIAL);
    jt(0);
    cm(RPG_CMD_WRITE, 8'h00, 0);
    cm(RPG_CMD_WRITE, 8'h01, 1);
    cm(RPG_CMD_ERASE, 8'h00, 0);
    cm(RPG_CMD_READ, 8'h01, 0);
    cm(RPG_CMD_GO, 8'h00, 1);
    $display("test partial done");
    rst(RPG_PAT_ERASE, RPG_LVL_ERASE);
    jt(0);
    cm(RPG_CMD_WRITE, 8'h01, 0);
    cm(RPG_CMD_ERASE, 8'h01, 0);
    cm(RPG_CMD_ERASEALL, 8'h00, 1);
    cm(RPG_CMD_WRITE, 8'h01, 1);
    $display("test erase done");
    rst(RPG_PAT_FULL, RPG_LVL_FULL);
    chk("active", bsp_active, 0);
    cm(RPG_CMD_INFO, 8'h00, 0);
    @(posedge core_clk);
    sw_reinvoke_req <= 1'b1;
    @(posedge core_clk);
    sw_reinvoke_req <= 1'b0;
    #1 chk("enter", bsp_enter, 1);
    @(posedge core_clk);
    #1 chk("active", bsp_active, 1);
    chk("uart", uart_route, 1);
    cm(RPG_CMD_WRITE, 8'h00, 1);
    jt(0);
    $display("test full done");
    summarize();
  end
endmodule
